// [src/rst_supervisor_pkg.sv]
package rst_supervisor_pkg;

  // ****************************************************************
  // Register map (word indices on adr_i[13:2], one aligned word each)
  // ****************************************************************
  localparam logic [11:0] SUPPLY_MONITOR_CTRL_IDX = 12'hd0c;
  localparam logic [11:0] WATCHDOG_MODE_CTRL_IDX  = 12'hf0f;
  localparam logic [11:0] IRQ_PENDING_IDX         = 12'hf0c;
  localparam logic [11:0] INTERRUPT_MASK_IDX      = 12'hf0b;
  localparam logic [11:0] STOP_RECOVERY_IDX       = 12'hf0a;
  localparam logic [11:0] RESET_STATUS_IDX        = 12'hf09;
  localparam logic [11:0] REFRESH_CMD_IDX         = 12'hf08;
  localparam int          ADDR_W                  = 14;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int         MON_EN_BIT       = 0;
  localparam int         MON_UV_BIT       = 1;
  localparam int         MON_OV_BIT       = 2;
  localparam logic [4:0] MON_RSVD_ONES    = 5'h1f;
  localparam int         SUPPLY_IRQ_BIT   = 5;
  localparam int         MODE_HALT_BIT    = 2;
  localparam int         MODE_STOP_BIT    = 3;
  localparam int         RECOV_DELAY_BIT  = 5;
  localparam logic [7:0] MODE_RESET_VAL   = 8'h0d;
  localparam logic [7:0] RECOV_RESET_VAL  = 8'h20;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ           = 125;
  localparam int MODE_WINDOW_CYC   = 120;  // Oscillator clocks after reset
  localparam int POR_TIME_US       = 5;    // Arbitrary hold length of reset timer
  localparam int POR_CYC           = POR_TIME_US * CLK_MHZ;
  localparam int TMO_BASE_MS       = 5;
  localparam int CYC_PER_MS        = 1000 * CLK_MHZ;
  localparam int WDG_CNT_W         = 40;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RUN_MODE,
    HALT_MODE,
    STOP_MODE
  } power_mode_type;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } wb_req_type;

endpackage

// [src/rst_supervisor.sv]
// What this block does
// - Monitor supply only while enable bit set
// - Over-voltage flag mirrors high-threshold comparator
// - Under-voltage flag mirrors low-threshold comparator
// - Enabled under-voltage raises supply interrupt request
// - Pending bit five latches until cleared
// - Interrupt serviced only when mask enabled
// - Top five bits read ones; flags read-only
// - One-shot reset timer holds internal reset
// - Timer starts: power-up, brownout, watchdog, recovery
// - Delay bit zero skips timer on recovery
// - Watchdog one-shot resets chip at terminal count
// - First refresh enables, later refreshes restart
// - Mode register writable only 120 clocks
// - Mode register reads never return contents
// - Stop recovery keeps mode register value
// - Bits three/two keep counting in STOP/HALT
// - Bits 6:4,1:0 select minimum time-out
// - Illegal upper select falls back to low bits
// - Time-out in STOP resets, keeps mode value
// - Time-out outside STOP reloads mode reset value
// - After watchdog reset, watchdog stays disabled
//
// Local design decision: the Wishbone register port.
module rst_supervisor
  import rst_supervisor_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int MS_CYCLES  = CYC_PER_MS
)(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Analog comparators and power events (asynchronous)
  input  wire logic              undervoltage_i,
  input  wire logic              overvoltage_i,
  input  wire logic              brownout_recover_i,
  input  wire logic              stop_recover_i,
  // Processor state
  input  wire logic              halt_mode_i,
  input  wire logic              stop_mode_i,
  // Results
  output logic                   chip_reset_o,
  output logic                   supply_irq_o,
  output logic                   wdg_wake_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]        uv_sync;
    logic [2:0]        ov_sync;
    logic [2:0]        bo_sync;
    logic [2:0]        sr_sync;
    logic              uv;
    logic              ov;
    logic              bo;
    logic              sr;
    logic              mon_en;
    logic              irq_pend;
    logic              irq_mask;
    logic [7:0]        recov;
    logic              was_recov;
    logic [7:0]        mode;
    logic [7:0]        win_cnt;
    logic [31:0]       por_cnt;
    logic              por_busy;
    logic              wdg_en;
    logic [WDG_CNT_W-1:0] wdg_cnt;
    logic              wake;
    logic              ack;
    logic [31:0]       rdata;
    logic              irq;
  } state_type;

  state_type s_q;
  state_type s_d;

  // Decoded bus access, one per request while ack is low
  logic            acc;
  logic            wr;
  logic [11:0]     idx;
  logic            refresh;
  logic            tmo;
  logic [2:0]      hi_sel;
  logic [WDG_CNT_W-1:0] limit;
  power_mode_type  pmode;

  assign idx     = adr_i[ADDR_W-1:2];
  assign acc     = cyc_i && stb_i && !s_q.ack;
  assign wr      = acc && we_i && sel_i[0];
  assign refresh = wr && (idx == REFRESH_CMD_IDX);
  assign hi_sel  = s_q.mode[6:4];
  assign pmode   = stop_mode_i ? STOP_MODE : (halt_mode_i ? HALT_MODE : RUN_MODE);

  // ****************************************************************
  // Time-out selection
  // ****************************************************************
  // Upper select counts only when exactly one bit is set
  always_comb
  begin
    unique case (hi_sel)
      3'h1:    limit = WDG_CNT_W'(64  * TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
      3'h2:    limit = WDG_CNT_W'(256 * TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
      3'h4:    limit = WDG_CNT_W'(1024 * TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
      default:
      begin
        unique case (s_q.mode[1:0])
          2'h0:    limit = WDG_CNT_W'(TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
          2'h1:    limit = WDG_CNT_W'(2 * TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
          2'h2:    limit = WDG_CNT_W'(4 * TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
          default: limit = WDG_CNT_W'(16 * TMO_BASE_MS) * WDG_CNT_W'(MS_CYCLES);
        endcase
      end
    endcase
  end

  // Terminal count reached while the counter is free to run
  assign tmo = s_q.wdg_en && !s_q.por_busy && (s_q.wdg_cnt == limit - WDG_CNT_W'(1));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic stall;
    logic sr_rise;
    logic start_por;
    stall   = 1'b0;
    sr_rise = 1'b0;
    start_por = 1'b0;
    s_d     = s_q;
    s_d.ack = 1'b0;

    // Three-stage pin synchronisers, change taken when stages 2 and 3 agree
    s_d.uv_sync = {s_q.uv_sync[1:0], undervoltage_i};
    s_d.ov_sync = {s_q.ov_sync[1:0], overvoltage_i};
    s_d.bo_sync = {s_q.bo_sync[1:0], brownout_recover_i};
    s_d.sr_sync = {s_q.sr_sync[1:0], stop_recover_i};
    if (s_q.uv_sync[1] == s_q.uv_sync[2]) s_d.uv = s_q.uv_sync[2];
    if (s_q.ov_sync[1] == s_q.ov_sync[2]) s_d.ov = s_q.ov_sync[2];
    if (s_q.bo_sync[1] == s_q.bo_sync[2]) s_d.bo = s_q.bo_sync[2];
    if (s_q.sr_sync[1] == s_q.sr_sync[2]) s_d.sr = s_q.sr_sync[2];
    sr_rise = s_d.sr && !s_q.sr;

    // Bus access: every request acked the next cycle, unmapped read zero
    if (acc)
    begin
      s_d.ack   = 1'b1;
      s_d.rdata = 32'h0;
      if (wr)
      begin
        unique case (idx)
          SUPPLY_MONITOR_CTRL_IDX: s_d.mon_en = dat_i[MON_EN_BIT];
          INTERRUPT_MASK_IDX:      s_d.irq_mask = dat_i[SUPPLY_IRQ_BIT];
          IRQ_PENDING_IDX:         if (!dat_i[SUPPLY_IRQ_BIT]) s_d.irq_pend = 1'b0;
          STOP_RECOVERY_IDX:       s_d.recov = dat_i[7:0];
          WATCHDOG_MODE_CTRL_IDX:  if (s_q.win_cnt != 8'h0) s_d.mode = dat_i[7:0];
          default:                 s_d.rdata = 32'h0;
        endcase
      end
      else
      begin
        unique case (idx)
          SUPPLY_MONITOR_CTRL_IDX: s_d.rdata = {24'h0, MON_RSVD_ONES,
                                                s_q.ov && s_q.mon_en,
                                                s_q.uv && s_q.mon_en,
                                                s_q.mon_en};
          IRQ_PENDING_IDX:         s_d.rdata = 32'(s_q.irq_pend) << SUPPLY_IRQ_BIT;
          INTERRUPT_MASK_IDX:      s_d.rdata = 32'(s_q.irq_mask) << SUPPLY_IRQ_BIT;
          STOP_RECOVERY_IDX:       s_d.rdata = {24'h0, s_q.recov};
          RESET_STATUS_IDX:        s_d.rdata = {31'h0, s_q.was_recov};
          default:                 s_d.rdata = 32'h0;
        endcase
      end
    end

    // Sticky pending bit, set beats clear
    if (s_q.mon_en && s_q.uv)
      s_d.irq_pend = 1'b1;
    // Request leaves only through the mask
    s_d.irq = s_d.irq_pend && s_d.irq_mask;

    // Mode window closes after 120 oscillator clocks
    if (!s_q.por_busy && s_q.win_cnt != 8'h0)
      s_d.win_cnt = s_q.win_cnt - 8'h1;

    // Watchdog: refresh enables or restarts from start count
    stall = (pmode == HALT_MODE && !s_q.mode[MODE_HALT_BIT]) ||
            (pmode == STOP_MODE && !s_q.mode[MODE_STOP_BIT]);
    s_d.wake = 1'b0;
    if (refresh)
    begin
      s_d.wdg_en  = 1'b1;
      s_d.wdg_cnt = '0;
    end
    else if (!s_q.wdg_en)
      s_d.wdg_cnt = '0;
    else if (!stall && !s_q.por_busy)
      s_d.wdg_cnt = s_q.wdg_cnt + WDG_CNT_W'(1);

    // Time-out: reset chip, behaviour depends on STOP
    if (tmo)
    begin
      start_por   = 1'b1;
      s_d.wdg_en  = 1'b0;
      s_d.wdg_cnt = '0;
      s_d.win_cnt = 8'(MODE_WINDOW_CYC);
      s_d.was_recov = 1'b0;
      if (pmode == STOP_MODE)
        s_d.wake = 1'b1;
      else
        s_d.mode = MODE_RESET_VAL;
    end

    // Brownout recovery restarts the timer like power-up
    if (s_d.bo && !s_q.bo)
    begin
      start_por     = 1'b1;
      s_d.mode      = MODE_RESET_VAL;
      s_d.wdg_en    = 1'b0;
      s_d.wdg_cnt   = '0;
      s_d.win_cnt   = 8'(MODE_WINDOW_CYC);
      s_d.was_recov = 1'b0;
    end

    // Stop recovery keeps mode, timer only if delay bit set
    if (sr_rise && pmode == STOP_MODE)
    begin
      s_d.was_recov = 1'b1;
      s_d.win_cnt   = 8'(MODE_WINDOW_CYC);
      if (s_q.recov[RECOV_DELAY_BIT])
        start_por = 1'b1;
    end

    // One-shot reset timer holds reset for its full period
    if (start_por)
    begin
      s_d.por_busy = 1'b1;
      s_d.por_cnt  = 32'(POR_CYCLES);
    end
    else if (s_q.por_busy)
    begin
      if (s_q.por_cnt == 32'h1)
        s_d.por_busy = 1'b0;
      s_d.por_cnt = s_q.por_cnt - 32'h1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Power-up reset starts the timer and opens the mode window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q           <= '0;
      s_q.recov     <= RECOV_RESET_VAL;
      s_q.mode      <= MODE_RESET_VAL;
      s_q.win_cnt   <= 8'(MODE_WINDOW_CYC);
      s_q.por_busy  <= 1'b1;
      s_q.por_cnt   <= 32'(POR_CYCLES);
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign dat_o        = s_q.rdata;
  assign ack_o        = s_q.ack;
  assign chip_reset_o = s_q.por_busy;
  assign supply_irq_o = s_q.irq;
  assign wdg_wake_o   = s_q.wake;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence tmo_seq;
    ce_i && tmo;
  endsequence

  sequence reset_held_seq;
    chip_reset_o [*2];
  endsequence

  a_wdg_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_seq |=> !s_q.wdg_en)
    else $error("watchdog still enabled after time-out");

  a_tmo_por: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_seq |=> reset_held_seq)
    else $error("time-out did not hold reset");

  a_mode_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_seq and (pmode == STOP_MODE) |=> $stable(s_q.mode) && wdg_wake_o)
    else $error("stop time-out lost mode value");

  a_mode_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    tmo_seq and (pmode != STOP_MODE) |=> s_q.mode == MODE_RESET_VAL)
    else $error("mode not reloaded on time-out");

  a_mode_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.win_cnt == 8'h0 && !tmo && !(s_d.bo && !s_q.bo) |=> $stable(s_q.mode))
    else $error("mode written after window");

  a_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.mon_en && s_q.uv |=> s_q.irq_pend)
    else $error("under-voltage not latched");

  a_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    supply_irq_o |-> s_q.irq_mask && s_q.irq_pend)
    else $error("interrupt without mask");

  a_counter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.wdg_en |-> s_q.wdg_cnt == '0)
    else $error("counter moved while disabled");

  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not one cycle");

  // Activity bit clear for the present mode holds the count still
  sequence paused_seq;
    (pmode == HALT_MODE && !s_q.mode[MODE_HALT_BIT]) ||
    (pmode == STOP_MODE && !s_q.mode[MODE_STOP_BIT]);
  endsequence

  // No refresh, time-out or brownout competes with the count on this edge
  sequence quiet_seq;
    ce_i && !refresh && !tmo && !(s_d.bo && !s_q.bo);
  endsequence

  // Refresh, pause, disable, reset hold, time-out and brownout all depart from a plain increment
  a_stall_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet_seq and paused_seq |=> $stable(s_q.wdg_cnt))
    else $error("watchdog counted while paused");

  a_refresh_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && refresh && !tmo && !(s_d.bo && !s_q.bo) |=> s_q.wdg_en && s_q.wdg_cnt == '0)
    else $error("refresh did not restart watchdog");

  // Reserved ones always read back; flags stay quiet while monitoring is off
  a_supply_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && acc && !wr && idx == SUPPLY_MONITOR_CTRL_IDX
    |=> dat_o[7:3] == MON_RSVD_ONES && (dat_o[2:1] == 2'h0 || s_q.mon_en))
    else $error("supply monitor read wrong");

  // The one-shot never lets go before its count is spent
  a_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s_q.por_busy && s_q.por_cnt != 32'h1 |=> chip_reset_o)
    else $error("reset released early");

  // Only a time-out can wake the chip
  a_wake_tmo: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !tmo |=> !wdg_wake_o)
    else $error("wake pulse without time-out");

  // A fast stop recovery, or no event at all, never starts the timer
  a_fast_recover: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !s_q.por_busy && !tmo && !(s_d.bo && !s_q.bo) &&
    !(s_d.sr && !s_q.sr && s_q.recov[RECOV_DELAY_BIT]) |=> !chip_reset_o)
    else $error("reset timer started without cause");

endmodule

// [test/rst_supervisor_test.sv]
module rst_supervisor_test
  import rst_supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and counters
  // ****************************************************************
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc_i = 1'b0;
  logic              stb_i = 1'b0;
  logic              we_i = 1'b0;
  logic [ADDR_W-1:0] adr_i = '0;
  logic [31:0]       dat_i = '0;
  logic [31:0]       dat_o;
  logic              ack_o;
  logic              uv_i = 1'b1;
  logic              ov_i = 1'b0;
  logic              bo_i = 1'b0;
  logic              sr_i = 1'b0;
  logic              halt_i = 1'b0;
  logic              stop_i = 1'b0;
  logic              chip_reset_o;
  logic              supply_irq_o;
  logic              wdg_wake_o;
  int                failures = 0;
  int                n_compared = 0;
  int                cycles = 0;
  int                wakes = 0;
  int                n;
  logic [7:0]        q;

  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("FAIL %0t got %h exp %h", $time, (a), (e)); end end

  // Short counts keep the run brief: 5 ms becomes 50 cycles
  rst_supervisor #(
    .POR_CYCLES (20),
    .MS_CYCLES  (10)
  ) u_rst_supervisor (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .ce_i               (1'b1),
    .cyc_i              (cyc_i),
    .stb_i              (stb_i),
    .we_i               (we_i),
    .adr_i              (adr_i),
    .sel_i              (4'h1),
    .dat_i              (dat_i),
    .dat_o              (dat_o),
    .ack_o              (ack_o),
    .undervoltage_i     (uv_i),
    .overvoltage_i      (ov_i),
    .brownout_recover_i (bo_i),
    .stop_recover_i     (sr_i),
    .halt_mode_i        (halt_i),
    .stop_mode_i        (stop_i),
    .chip_reset_o       (chip_reset_o),
    .supply_irq_o       (supply_irq_o),
    .wdg_wake_o         (wdg_wake_o)
  );

  // Clock, hang guard and wake pulse tally
  always #4 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cycles++;
    if (wdg_wake_o === 1'b1) wakes++;
    if (cycles == 6000)
    begin
      failures++;
      final_report();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input int w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= (w != 0);
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  // Cycles until the internal reset rises, then how long it stays
  task automatic to_reset(output int c);
    c = 0;
    while (chip_reset_o !== 1'b1)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask

  task automatic hold_len(output int c);
    c = 0;
    while (chip_reset_o !== 1'b0)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask

  // Register pipelines blur edges by up to three cycles either way
  function automatic logic near(input int c, input int e);
    return (c >= e - 3) && (c <= e + 3);
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    hold_len(n);
    `CHK(near(n, 20), 1'b1)
    // Two upper bits set with low select 00: 5 ms
    wb(1, WATCHDOG_MODE_CTRL_IDX, 8'h30);
    wb(0, WATCHDOG_MODE_CTRL_IDX, 8'h00);
    `CHK(q, 8'h00)
    wb(0, SUPPLY_MONITOR_CTRL_IDX, 8'h00);
    `CHK(q, 8'hf8)
    wb(0, IRQ_PENDING_IDX, 8'h00);
    `CHK(q[5], 1'b0)
    wb(1, SUPPLY_MONITOR_CTRL_IDX, 8'hff);
    // No port mode writes while the under-voltage flag is watched
    repeat (5) @(posedge clk_i);
    wb(0, SUPPLY_MONITOR_CTRL_IDX, 8'h00);
    `CHK(q, 8'hfb)
    uv_i <= 1'b0;
    ov_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    wb(0, SUPPLY_MONITOR_CTRL_IDX, 8'h00);
    `CHK(q, 8'hfd)
    wb(0, IRQ_PENDING_IDX, 8'h00);
    `CHK(q[5], 1'b1)
    `CHK(supply_irq_o, 1'b0)
    wb(1, INTERRUPT_MASK_IDX, 8'h20);
    repeat (3) @(posedge clk_i);
    `CHK(supply_irq_o, 1'b1)
    wb(1, IRQ_PENDING_IDX, 8'h00);
    repeat (3) @(posedge clk_i);
    `CHK(supply_irq_o, 1'b0)
    ov_i <= 1'b0;
    wb(1, REFRESH_CMD_IDX, 8'h00);
    to_reset(n);
    `CHK(near(n, 50), 1'b1)
    hold_len(n);
    `CHK(near(n, 20), 1'b1)
    // Later refresh restarts the count from the start
    wb(1, WATCHDOG_MODE_CTRL_IDX, 8'h00);
    wb(1, REFRESH_CMD_IDX, 8'h00);
    repeat (40) @(posedge clk_i);
    wb(1, REFRESH_CMD_IDX, 8'h00);
    to_reset(n);
    `CHK(near(n, 50), 1'b1)
    hold_len(n);
    repeat (150) @(posedge clk_i);
    `CHK(chip_reset_o, 1'b0)
    // Late write ignored; reset value selects 10 ms
    wb(1, WATCHDOG_MODE_CTRL_IDX, 8'h00);
    wb(1, REFRESH_CMD_IDX, 8'h00);
    to_reset(n);
    `CHK(near(n, 100), 1'b1)
    hold_len(n);
    // HALT bit clear pauses the count
    wb(1, WATCHDOG_MODE_CTRL_IDX, 8'h08);
    wb(1, REFRESH_CMD_IDX, 8'h00);
    halt_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    halt_i <= 1'b0;
    to_reset(n);
    `CHK(near(n, 50), 1'b1)
    hold_len(n);
    wb(1, WATCHDOG_MODE_CTRL_IDX, 8'h08);
    wb(1, REFRESH_CMD_IDX, 8'h00);
    stop_i <= 1'b1;
    to_reset(n);
    `CHK(near(n, 50), 1'b1)
    stop_i <= 1'b0;
    hold_len(n);
    `CHK(wakes, 1)
    wb(1, REFRESH_CMD_IDX, 8'h00);
    to_reset(n);
    `CHK(near(n, 50), 1'b1)
    hold_len(n);
    // Brownout recovery and delayed stop recovery rerun the timer
    bo_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bo_i <= 1'b0;
    to_reset(n);
    hold_len(n);
    `CHK(near(n, 20), 1'b1)
    stop_i <= 1'b1;
    sr_i   <= 1'b1;
    repeat (3) @(posedge clk_i);
    sr_i <= 1'b0;
    to_reset(n);
    hold_len(n);
    `CHK(near(n, 20), 1'b1)
    stop_i <= 1'b0;
    wb(1, STOP_RECOVERY_IDX, 8'h00);
    stop_i <= 1'b1;
    sr_i   <= 1'b1;
    repeat (3) @(posedge clk_i);
    sr_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    `CHK(chip_reset_o, 1'b0)
    final_report();
  end

endmodule
